/* File: hmiu_top.sv */
// Prioritised interrupt controller of the hub microcontroller
// Summary of operation
// R1 - Smallest pending enabled vector number is serviced first.
// R2 - After reset the core fetches from address 0x0000.
// R3 - Two-byte vector slots from 0x0002 up to 0x0018.
// R4 - Endpoint vectors 0x0008 to 0x0010: A0, A1, A2, B0, B1.
// R5 - Service waits for instruction end, then 10-cycle call.
// R6 - Upstream SE0 of 12 us may, over 16 us must, mean bus reset.
// R7 - Bus reset sets status bit 5.
// R8 - Bus reset clears device address and hub port registers.
// R9 - Bus reset request raised when SE0 is released.
// R10 - Bus reset during power-on start-up delay aborts the delay.
// R11 - Periodic requests every 128 us and 1.024 ms.
// R12 - Endpoint request on final acknowledge; unacknowledged IN raises none.
// R13 - Hub request on connect change, or enabled-port babble or resume.
// R14 - Connect change on a forced port raises no hub request.
// R15 - One shared pin request; triggered pin locks out the others.
// R16 - Pin enables untouched on service; source pin not recorded.
// R17 - Slave receive byte interrupts; first byte sets address match.
// R18 - Slave stop sets stop flag unless last byte was not acknowledged.
// R19 - Slave transmit byte interrupts and reports master acknowledge.
// R20 - Master bytes interrupt; clearing master select issues stop.
// R21 - Lost arbitration clears master select, sets flag, waits for stop.
// R22 - Continue/busy cleared before byte interrupts; one write resumes.
// R23 - Per-source pending latch, requesting only while enabled.
// R24 - Service clears global enable and pending latch, calls vector.
// R25 - Any reset clears both enable registers; here only resetn_i clears them, and a bus reset leaves them.
`timescale 1ns/10ps
module hmiu_top #(
   parameter int TICK_FAST_CYCLES = hmiu_pkg::TICK_FAST_CYC
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic se0_i,
   input wire logic por_delay_active_i,
   input wire logic instr_done_i,
   input wire logic ei_i,
   input wire logic di_i,
   input wire logic reti_i,
   input wire logic gie_wr_i,
   input wire logic [7:0] gie_wdata_i,
   input wire logic epie_wr_i,
   input wire logic [4:0] epie_wdata_i,
   input wire logic busrst_flag_clr_i,
   input wire logic [hmiu_pkg::NUM_EP-1:0] ep_in_host_ack_i,
   input wire logic [hmiu_pkg::NUM_EP-1:0] ep_out_dev_ack_i,
   input wire hmiu_pkg::hmiu_hub_ev_t hub_ev_i,
   input wire logic dac_event_i,
   input wire logic [hmiu_pkg::NUM_PIN-1:0] pin_active_i,
   input wire logic [hmiu_pkg::NUM_PIN-1:0] pin_enable_i,
   input wire hmiu_pkg::hmiu_i2c_ev_t i2c_ev_i,
   input wire logic i2c_csr_wr_i,
   input wire hmiu_pkg::hmiu_i2c_csr_t i2c_csr_wdata_i,
   output logic [7:0] gie_rdata_o,
   output logic [4:0] epie_rdata_o,
   output logic gie_o,
   output logic irq_sense_o,
   output logic busrst_flag_o,
   output logic [7:0] psc_status_o,
   output logic addr_clear_o,
   output logic hub_clear_o,
   output logic startup_abort_o,
   output logic call_busy_o,
   output logic fetch_valid_o,
   output logic [13:0] fetch_addr_o,
   output logic [hmiu_pkg::NUM_SRC-1:0] pending_o,
   output hmiu_pkg::hmiu_i2c_csr_t i2c_csr_o,
   output logic i2c_stop_issue_o
);
   typedef enum logic [1:0] {
      HMIU_ST_IDLE = 2'b01,
      HMIU_ST_CALL = 2'b10
   } hmiu_state_t;

   hmiu_state_t state_reg;
   logic [7:0] gie_reg;
   logic [4:0] epie_reg;
   logic cpu_gie_reg;
   logic busrst_flag_reg;
   logic [hmiu_pkg::NUM_SRC-1:0] pend_reg;
   logic [hmiu_pkg::NUM_SRC-1:0] pend_set;
   logic [hmiu_pkg::NUM_SRC-1:0] pend_clr;
   logic [hmiu_pkg::NUM_SRC-1:0] src_en;
   logic [hmiu_pkg::NUM_SRC-1:0] req;
   logic [3:0] win_idx;
   logic win_any;
   logic take;
   logic [3:0] call_cnt_reg;
   logic [13:0] fetch_addr_reg;
   logic fetch_valid_reg;
   logic [14:0] fast_cnt_reg;
   logic [2:0] slow_cnt_reg;
   logic tick_fast;
   logic tick_slow;
   logic se0_detect;
   logic se0_release;
   logic addr_clr_reg;
   logic abort_reg;
   logic hub_event;
   logic [hmiu_pkg::NUM_PIN-1:0] pin_hit;
   logic pin_locked_reg;
   logic [hmiu_pkg::PIN_IDX_W-1:0] pin_owner_reg;
   logic pin_fire;
   logic [hmiu_pkg::PIN_IDX_W-1:0] pin_first;
   hmiu_pkg::hmiu_i2c_csr_t csr_reg;
   logic stop_issue_reg;
   logic arb_wait_reg;
   logic i2c_irq;
   logic slave_stop_ok;

   localparam logic [14:0] FAST_LAST = 15'(TICK_FAST_CYCLES - 1);
   localparam logic [2:0] SLOW_LAST = 3'(hmiu_pkg::TICK_SLOW_DIV - 1);
   localparam logic [3:0] CALL_LAST = 4'(hmiu_pkg::CALL_CYC - 1);

   // Upstream bus reset detector
   hmiu_se0_detect u_se0 (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .se0_i(se0_i),
      .detect_o(se0_detect),
      .release_o(se0_release),
      .active_o()
   );
   // Bus reset side effects on detection
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_clr_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else begin
         addr_clr_reg <= se0_detect; // see R8
         abort_reg <= se0_detect && por_delay_active_i; // see R10
      end
   end
   // Bus reset status flag, set wins over clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busrst_flag_reg <= 1'b0;
      end else if (se0_detect) begin
         busrst_flag_reg <= 1'b1; // see R7
      end else if (busrst_flag_clr_i) begin
         busrst_flag_reg <= 1'b0;
      end
   end
   // Periodic tick generators
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fast_cnt_reg <= '0;
         slow_cnt_reg <= '0;
      end else if (tick_fast) begin
         fast_cnt_reg <= '0;
         slow_cnt_reg <= tick_slow ? 3'h0 : slow_cnt_reg + 1'b1;
      end else begin
         fast_cnt_reg <= fast_cnt_reg + 1'b1;
      end
   end
   assign tick_fast = fast_cnt_reg == FAST_LAST; // see R11
   assign tick_slow = tick_fast && slow_cnt_reg == SLOW_LAST; // see R11
   // Hub event gating per port
   assign hub_event = |(hub_ev_i.connect_change & ~hub_ev_i.forced) // see R14
      | |((hub_ev_i.babble | hub_ev_i.resume) & hub_ev_i.port_enable); // see R13
   // Pin trigger lockout
   assign pin_hit = pin_active_i & pin_enable_i;
   always_comb begin
      pin_first = '0;
      for (int i = hmiu_pkg::NUM_PIN - 1; i >= 0; i--) begin
         if (pin_hit[i]) begin
            pin_first = hmiu_pkg::PIN_IDX_W'(i);
         end
      end
   end
   assign pin_fire = !pin_locked_reg && |pin_hit; // see R15

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_locked_reg <= 1'b0;
         pin_owner_reg <= '0;
      end else if (pin_fire) begin
         pin_locked_reg <= 1'b1;
         pin_owner_reg <= pin_first;
      end else if (pin_locked_reg && !pin_hit[pin_owner_reg]) begin
         pin_locked_reg <= 1'b0; // see R15
      end
   end
   // Stop counts only while the ack bit is set, which an acknowledged transmitted byte sets
   assign slave_stop_ok = i2c_ev_i.bus_stop && !csr_reg.master_select_bit
      && !arb_wait_reg && csr_reg.ack; // see R18
   // Two-wire byte, stop and arbitration interrupt points
   assign i2c_irq = i2c_ev_i.slave_rx_byte // see R17
      || i2c_ev_i.slave_tx_byte // see R19
      || i2c_ev_i.master_byte // see R20
      || slave_stop_ok
      || (arb_wait_reg && i2c_ev_i.bus_stop); // see R21
   // Two-wire status and control bits; hardware events win
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         csr_reg <= hmiu_pkg::I2C_CSR_RESET;
         stop_issue_reg <= 1'b0;
         arb_wait_reg <= 1'b0;
      end else begin
         stop_issue_reg <= i2c_csr_wr_i && csr_reg.master_select_bit
            && !i2c_csr_wdata_i.master_select_bit
            && !i2c_ev_i.arb_lost; // see R20
         if (i2c_csr_wr_i) begin
            csr_reg <= i2c_csr_wdata_i;
         end
         if (i2c_ev_i.slave_rx_byte) begin
            csr_reg.addr_match <= i2c_ev_i.first_byte; // see R17
         end
         if (slave_stop_ok) begin
            csr_reg.stop_received <= 1'b1; // see R18
         end
         if (i2c_ev_i.slave_tx_byte) begin
            csr_reg.ack <= i2c_ev_i.master_acked; // see R19
         end
         if (i2c_ev_i.slave_rx_byte || i2c_ev_i.slave_tx_byte
            || i2c_ev_i.master_byte) begin
            csr_reg.continue_busy <= 1'b0; // see R22
         end
         if (i2c_ev_i.arb_lost) begin
            csr_reg.master_select_bit <= 1'b0; // see R21
            csr_reg.arbitration_lost_flag <= 1'b1; // see R21
            arb_wait_reg <= 1'b1;
         end else if (arb_wait_reg && i2c_ev_i.bus_stop) begin
            arb_wait_reg <= 1'b0;
         end
      end
   end
   // Per-source request pulses
   always_comb begin
      pend_set = '0;
      pend_set[hmiu_pkg::SRC_BUSRST] = se0_release; // see R9
      pend_set[hmiu_pkg::SRC_T128] = tick_fast;
      pend_set[hmiu_pkg::SRC_T1024] = tick_slow;
      pend_set[hmiu_pkg::SRC_HUB] = hub_event;
      pend_set[hmiu_pkg::SRC_DAC] = dac_event_i;
      pend_set[hmiu_pkg::SRC_GPIO] = pin_fire; // see R16
      pend_set[hmiu_pkg::SRC_I2C] = i2c_irq;
      pend_set[hmiu_pkg::SRC_EP0 +: hmiu_pkg::NUM_EP] =
         ep_in_host_ack_i | ep_out_dev_ack_i; // see R12
   end
   // Endpoint enables, one per endpoint
   for (genvar e = 0; e < hmiu_pkg::NUM_EP; e++) begin : g_ep
      assign src_en[hmiu_pkg::SRC_EP0 + e] = epie_reg[e];
   end
   // Global enable mapping for the other sources
   assign src_en[hmiu_pkg::SRC_BUSRST] = gie_reg[hmiu_pkg::GIE_BUSRST_BIT];
   assign src_en[hmiu_pkg::SRC_T128] = gie_reg[hmiu_pkg::GIE_T128_BIT];
   assign src_en[hmiu_pkg::SRC_T1024] = gie_reg[hmiu_pkg::GIE_T1024_BIT];
   assign src_en[hmiu_pkg::SRC_HUB] = gie_reg[hmiu_pkg::GIE_HUB_BIT];
   assign src_en[hmiu_pkg::SRC_DAC] = gie_reg[hmiu_pkg::GIE_DAC_BIT];
   assign src_en[hmiu_pkg::SRC_GPIO] = gie_reg[hmiu_pkg::GIE_GPIO_BIT];
   assign src_en[hmiu_pkg::SRC_I2C] = gie_reg[hmiu_pkg::GIE_I2C_BIT];
   assign req = pend_reg & src_en; // see R23
   // Lowest vector number wins
   always_comb begin
      win_idx = '0;
      win_any = 1'b0;
      for (int i = hmiu_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            win_idx = 4'(i); // see R1
            win_any = 1'b1;
         end
      end
   end
   assign take = state_reg == HMIU_ST_IDLE && cpu_gie_reg && win_any
      && instr_done_i; // see R5
   // Pending latches; a new event beats the service clear
   always_comb begin
      pend_clr = '0;
      if (take) begin
         pend_clr[win_idx] = 1'b1; // see R24
      end
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~pend_clr) | pend_set; // see R23
      end
   end
   // Enable registers, cleared by resetn_i only; a bus reset leaves them unchanged
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gie_reg <= hmiu_pkg::GIE_RESET; // see R25
         epie_reg <= hmiu_pkg::EPIE_RESET; // see R25
      end else begin
         if (gie_wr_i) begin
            gie_reg <= gie_wdata_i & hmiu_pkg::GIE_MASK;
         end
         if (epie_wr_i) begin
            epie_reg <= epie_wdata_i;
         end
      end
   end

   // Processor global enable; service clears it first
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_gie_reg <= 1'b0;
      end else if (take || di_i) begin
         cpu_gie_reg <= 1'b0; // see R24
      end else if (ei_i || reti_i) begin
         cpu_gie_reg <= 1'b1;
      end
   end

   // Service sequencer with fixed call length
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= HMIU_ST_IDLE;
         call_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            HMIU_ST_IDLE: begin
               call_cnt_reg <= '0;
               if (take) begin
                  state_reg <= HMIU_ST_CALL;
               end
            end
            HMIU_ST_CALL: begin
               call_cnt_reg <= call_cnt_reg + 1'b1;
               if (call_cnt_reg == CALL_LAST) begin
                  state_reg <= HMIU_ST_IDLE; // see R5
               end
            end
         endcase
      end
   end

   // Fetch address: reset entry, then vector slots
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fetch_addr_reg <= hmiu_pkg::RESET_ADDR; // see R2
         fetch_valid_reg <= 1'b1; // see R2
      end else begin
         fetch_valid_reg <= state_reg == HMIU_ST_CALL
            && call_cnt_reg == CALL_LAST;
         if (take) begin
            fetch_addr_reg <= hmiu_pkg::VEC_BASE
               + {9'h000, win_idx, 1'b0}; // see R3 see R4
         end
      end
   end

   // Output drive
   assign gie_rdata_o = gie_reg;
   assign epie_rdata_o = epie_reg;
   assign gie_o = cpu_gie_reg;
   assign irq_sense_o = |req;
   assign busrst_flag_o = busrst_flag_reg;
   always_comb begin
      psc_status_o = 8'h00;
      psc_status_o[hmiu_pkg::PSC_BUSRST_BIT] = busrst_flag_reg;
      psc_status_o[2] = cpu_gie_reg;
      psc_status_o[7] = |req;
   end
   assign addr_clear_o = addr_clr_reg;
   assign hub_clear_o = addr_clr_reg; // see R8
   assign startup_abort_o = abort_reg;
   assign call_busy_o = state_reg == HMIU_ST_CALL;
   assign fetch_valid_o = fetch_valid_reg;
   assign fetch_addr_o = fetch_addr_reg;
   assign pending_o = pend_reg;
   assign i2c_csr_o = csr_reg;
   assign i2c_stop_issue_o = stop_issue_reg;
endmodule

/* File: hmiu_pkg.sv */
// Shared constants and carrier types for the hub interrupt unit
package hmiu_pkg;
   // Clock rate and derived cycle counts
   localparam int CLK_MHZ = 200;
   localparam int SE0_MIN_NS = 12000;
   localparam int SE0_MAX_NS = 16000;
   localparam int SE0_MIN_CYC = (SE0_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int SE0_MAX_CYC = (SE0_MAX_NS * CLK_MHZ) / 1000;
   localparam int TICK_FAST_US = 128;
   localparam int TICK_FAST_CYC = TICK_FAST_US * CLK_MHZ;
   localparam int TICK_SLOW_NS = 1024000;
   localparam int TICK_SLOW_DIV = TICK_SLOW_NS / (TICK_FAST_US * 1000);
   localparam int CALL_CYC = 10;
   localparam int SE0_CNT_W = 13;

   // Source numbering, equal to vector number minus one
   localparam int NUM_SRC = 12;
   localparam int SRC_BUSRST = 0;
   localparam int SRC_T128 = 1;
   localparam int SRC_T1024 = 2;
   localparam int SRC_EP0 = 3;
   localparam int NUM_EP = 5;
   localparam int SRC_HUB = 8;
   localparam int SRC_DAC = 9;
   localparam int SRC_GPIO = 10;
   localparam int SRC_I2C = 11;
   localparam int NUM_PORT = 4;
   localparam int NUM_PIN = 8;
   localparam int PIN_IDX_W = 3;

   // Program addresses
   localparam logic [13:0] RESET_ADDR = 14'h0000;
   localparam logic [13:0] VEC_BASE = 14'h0002;

   // Global enable register fields
   localparam int GIE_BUSRST_BIT = 0;
   localparam int GIE_T128_BIT = 1;
   localparam int GIE_T1024_BIT = 2;
   localparam int GIE_HUB_BIT = 3;
   localparam int GIE_DAC_BIT = 4;
   localparam int GIE_GPIO_BIT = 5;
   localparam int GIE_I2C_BIT = 6;
   localparam logic [7:0] GIE_RESET = 8'h00;
   localparam logic [7:0] GIE_MASK = 8'h7f;
   localparam logic [4:0] EPIE_RESET = 5'h00;
   localparam int PSC_BUSRST_BIT = 5;

   // Hub repeater event group
   typedef struct packed {
      logic [NUM_PORT-1:0] connect_change;
      logic [NUM_PORT-1:0] forced;
      logic [NUM_PORT-1:0] babble;
      logic [NUM_PORT-1:0] resume;
      logic [NUM_PORT-1:0] port_enable;
   } hmiu_hub_ev_t;

   // Two-wire engine event group
   typedef struct packed {
      logic slave_rx_byte;
      logic first_byte;
      logic slave_tx_byte;
      logic master_acked;
      logic master_byte;
      logic arb_lost;
      logic bus_stop;
   } hmiu_i2c_ev_t;

   // Two-wire status and control bits
   typedef struct packed {
      logic addr_match;
      logic stop_received;
      logic ack;
      logic master_select_bit;
      logic arbitration_lost_flag;
      logic continue_busy;
   } hmiu_i2c_csr_t;

   localparam hmiu_i2c_csr_t I2C_CSR_RESET = '0;
endpackage

/* File: hmiu_se0_detect.sv */
// Upstream single-ended-zero bus reset detector
`timescale 1ns/10ps
module hmiu_se0_detect (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic se0_i,
   output logic detect_o,
   output logic release_o,
   output logic active_o
);
   logic [hmiu_pkg::SE0_CNT_W-1:0] cnt_reg;
   logic active_reg;
   logic det_pulse_reg;
   logic rel_pulse_reg;
   localparam logic [hmiu_pkg::SE0_CNT_W-1:0] LIMIT =
      hmiu_pkg::SE0_CNT_W'(hmiu_pkg::SE0_MIN_CYC - 1);

   // Count length of the current SE0 state
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= '0;
      end else if (!se0_i) begin
         cnt_reg <= '0;
      end else if (cnt_reg != LIMIT) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // Recognise at 12 us, well inside the 16 us bound
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         active_reg <= 1'b0;
         det_pulse_reg <= 1'b0;
         rel_pulse_reg <= 1'b0;
      end else begin
         det_pulse_reg <= se0_i && !active_reg && cnt_reg == LIMIT; // see R6
         rel_pulse_reg <= active_reg && !se0_i; // see R9
         if (se0_i && cnt_reg == LIMIT) begin
            active_reg <= 1'b1;
         end else if (!se0_i) begin
            active_reg <= 1'b0;
         end
      end
   end

   assign detect_o = det_pulse_reg;
   assign release_o = rel_pulse_reg;
   assign active_o = active_reg;
endmodule

/* File: hmiu_core_model.sv */
// Processor core model giving instruction-end strobes
`timescale 1ns/10ps
module hmiu_core_model #(
   parameter int GAP = 3
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic slow_i,
   output logic instr_done_o
);
   logic [3:0] cnt_reg;
   // Cycle count within the current instruction
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 4'h0;
      end else if (instr_done_o) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   // Short or long instructions, so service waits differ
   assign instr_done_o = cnt_reg == (slow_i ? 4'h8 : 4'(GAP - 1));
endmodule

/* File: hmiu_top_properties.sv */
// Port-level assertions for the hub interrupt unit
`timescale 1ns/10ps
module hmiu_chk (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic se0_i,
   input wire logic instr_done_i,
   input wire hmiu_pkg::hmiu_hub_ev_t hub_ev_i,
   input wire hmiu_pkg::hmiu_i2c_ev_t i2c_ev_i,
   input wire logic i2c_csr_wr_i,
   input wire hmiu_pkg::hmiu_i2c_csr_t i2c_csr_wdata_i,
   input wire logic [7:0] gie_rdata_o,
   input wire logic [4:0] epie_rdata_o,
   input wire logic gie_o,
   input wire logic irq_sense_o,
   input wire logic busrst_flag_o,
   input wire logic [7:0] psc_status_o,
   input wire logic addr_clear_o,
   input wire logic hub_clear_o,
   input wire logic call_busy_o,
   input wire logic fetch_valid_o,
   input wire logic [13:0] fetch_addr_o,
   input wire logic [hmiu_pkg::NUM_SRC-1:0] pending_o,
   input wire hmiu_pkg::hmiu_i2c_csr_t i2c_csr_o,
   input wire logic i2c_stop_issue_o
);
   logic [11:0] en;
   logic [13:0] exp_addr;
   logic take;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   // Enable mask in source order, and the winning vector
   assign en = {gie_rdata_o[6:3], epie_rdata_o, gie_rdata_o[2:0]};
   always_comb begin
      exp_addr = hmiu_pkg::VEC_BASE;
      for (int i = 11; i >= 0; i--) begin
         if (pending_o[i] && en[i]) begin
            exp_addr = hmiu_pkg::VEC_BASE + 14'(2 * i);
         end
      end
   end
   assign take = !call_busy_o && gie_o && irq_sense_o && instr_done_i;
   property p_call;
      take |=> call_busy_o [*8] ##1 call_busy_o [*2] ##1 fetch_valid_o;
   endproperty
   a_call: assert property (p_call) else $error("call length wrong");
   property p_vec;
      take |=> fetch_addr_o == $past(exp_addr) && !gie_o;
   endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_irq;
      irq_sense_o == |(pending_o & en);
   endproperty
   a_irq: assert property (p_irq) else $error("irq sense wrong");
   property p_psc;
      psc_status_o[5] == busrst_flag_o && psc_status_o[2] == gie_o
         && psc_status_o[7] == irq_sense_o;
   endproperty
   a_psc: assert property (p_psc) else $error("status bits wrong");
   property p_clr;
      addr_clear_o |-> hub_clear_o && $past(se0_i, 2);
   endproperty
   a_clr: assert property (p_clr) else $error("clear pulse wrong");
   property p_hub;
      |(hub_ev_i.connect_change & ~hub_ev_i.forced) |=> pending_o[8];
   endproperty
   a_hub: assert property (p_hub) else $error("hub request lost");
   property p_arb;
      i2c_ev_i.arb_lost |=> !i2c_csr_o.master_select_bit
         && i2c_csr_o.arbitration_lost_flag;
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration bits");
   property p_rx;
      i2c_ev_i.slave_rx_byte |=> !i2c_csr_o.continue_busy
         && i2c_csr_o.addr_match == $past(i2c_ev_i.first_byte);
   endproperty
   a_rx: assert property (p_rx) else $error("receive bits wrong");
   property p_stop;
      i2c_csr_wr_i && i2c_csr_o.master_select_bit && !i2c_ev_i.arb_lost
         && !i2c_csr_wdata_i.master_select_bit |=> i2c_stop_issue_o;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop issued");
endmodule
bind hmiu_top hmiu_chk i_hmiu_chk (.*);

/* File: hmiu_top_bench.sv */
// Self-checking bench for the hub interrupt unit
`timescale 1ns/10ps
module hmiu_top_bench;
   localparam int FAST = 200;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic se0 = 1'b0, por = 1'b0, done, slow = 1'b0;
   logic ei = 1'b0, reti = 1'b0, gie_wr = 1'b0, epie_wr = 1'b0;
   logic bclr = 1'b0, dac = 1'b0, csr_wr = 1'b0;
   logic [7:0] gie_wd = 8'h00, pin_act = 8'h00, pin_en = 8'h00;
   logic [4:0] epie_wd = 5'h00, ep_in = 5'h00, ep_out = 5'h00;
   hmiu_pkg::hmiu_hub_ev_t hub = '0;
   hmiu_pkg::hmiu_i2c_ev_t i2c = '0;
   hmiu_pkg::hmiu_i2c_csr_t csr_wd = '0, csr;
   logic [7:0] gie_rd, psc;
   logic [4:0] epie_rd;
   logic gie, irq, bflag, aclr, hclr, sabort, busy, fv, stop_iss;
   logic [13:0] faddr;
   logic [11:0] pend;
   logic sa_seen = 1'b0, st_seen = 1'b0;
   int err_total = 0;
   int comparisons = 0;

   hmiu_core_model #(.GAP(3)) i_hmiu_core_model (.clock_i(clock_i),
      .resetn_i(resetn_i), .slow_i(slow), .instr_done_o(done));
   hmiu_top #(.TICK_FAST_CYCLES(FAST)) i_hmiu_top (.clock_i(clock_i),
      .resetn_i(resetn_i), .se0_i(se0), .por_delay_active_i(por),
      .instr_done_i(done), .ei_i(ei), .di_i(1'b0), .reti_i(reti),
      .gie_wr_i(gie_wr), .gie_wdata_i(gie_wd), .epie_wr_i(epie_wr),
      .epie_wdata_i(epie_wd), .busrst_flag_clr_i(bclr),
      .ep_in_host_ack_i(ep_in), .ep_out_dev_ack_i(ep_out), .hub_ev_i(hub),
      .dac_event_i(dac), .pin_active_i(pin_act), .pin_enable_i(pin_en),
      .i2c_ev_i(i2c), .i2c_csr_wr_i(csr_wr), .i2c_csr_wdata_i(csr_wd),
      .gie_rdata_o(gie_rd), .epie_rdata_o(epie_rd), .gie_o(gie),
      .irq_sense_o(irq), .busrst_flag_o(bflag), .psc_status_o(psc),
      .addr_clear_o(aclr), .hub_clear_o(hclr), .startup_abort_o(sabort),
      .call_busy_o(busy), .fetch_valid_o(fv), .fetch_addr_o(faddr),
      .pending_o(pend), .i2c_csr_o(csr), .i2c_stop_issue_o(stop_iss));

   // Clock and sticky capture of one-cycle pulses
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      sa_seen <= sa_seen | sabort;
      st_seen <= st_seen | stop_iss;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Bounded wait: 12 fetch strobe, 13 address clear, else a pending bit
   task automatic wait_for(input int b, input int lim);
      int n;
      n = 0;
      while ((b == 12 ? fv : b == 13 ? aclr : pend[b]) !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      if (n == lim) begin
         err_total++;
         conclude();
      end
   endtask
   task automatic wr_gie(input logic [7:0] v);
      gie_wd = v;
      gie_wr = 1'b1;
      tick(1);
      gie_wr = 1'b0;
   endtask
   // Re-enable by either instruction, then judge the vector fetched
   task automatic service(input int idx);
      if (idx % 2 == 1) begin
         reti = 1'b1;
      end else begin
         ei = 1'b1;
      end
      tick(1);
      ei = 1'b0;
      reti = 1'b0;
      wait_for(12, 100);
      chk(faddr, 32'(hmiu_pkg::VEC_BASE) + 32'(2 * idx));
      chk(gie, 1'b0);
      if (idx > 2) begin
         chk(pend[idx], 1'b0);
      end
   endtask
   task automatic t_reset;
      resetn_i = 1'b0;
      tick(10);
      chk({fv, faddr}, 32'h4000);
      chk({gie_rd, epie_rd}, 32'h0);
      resetn_i = 1'b1;
      tick(2);
   endtask
   task automatic t_busrst;
      se0 = 1'b1;
      tick(2000);
      se0 = 1'b0;
      tick(3);
      chk({bflag, pend[0]}, 2'b00);
      por = 1'b1;
      se0 = 1'b1;
      wait_for(13, 3300);
      chk(hclr, 1'b1);
      tick(2);
      chk({bflag, sa_seen, pend[0]}, 3'b110);
      se0 = 1'b0;
      por = 1'b0;
      tick(3);
      chk(pend[0], 1'b1);
      bclr = 1'b1;
      tick(1);
      bclr = 1'b0;
      tick(1);
      chk(bflag, 1'b0);
   endtask
   task automatic t_hub;
      hub.forced = 4'h1;
      hub.connect_change = 4'h1;
      tick(1);
      hub.connect_change = 4'h0;
      hub.babble = 4'h2;
      tick(1);
      hub.babble = 4'h0;
      tick(1);
      chk(pend[8], 1'b0);
      hub.port_enable = 4'h2;
      hub.resume = 4'h2;
      tick(1);
      hub.resume = 4'h0;
      tick(1);
      chk(pend[8], 1'b1);
      hub.connect_change = 4'h2;
      tick(1);
      hub.connect_change = 4'h0;
   endtask
   task automatic t_i2c;
      csr_wd.master_select_bit = 1'b1;
      csr_wd.continue_busy = 1'b1;
      csr_wr = 1'b1;
      tick(1);
      csr_wr = 1'b0;
      i2c.arb_lost = 1'b1;
      tick(1);
      i2c.arb_lost = 1'b0;
      tick(1);
      chk({csr.master_select_bit, csr.arbitration_lost_flag}, 2'b01);
      chk(pend[11], 1'b0);
      i2c.bus_stop = 1'b1;
      tick(1);
      i2c.bus_stop = 1'b0;
      tick(1);
      chk(pend[11], 1'b1);
      csr_wr = 1'b1;
      tick(1);
      csr_wd.master_select_bit = 1'b0;
      tick(1);
      csr_wr = 1'b0;
      tick(2);
      chk(st_seen, 1'b1);
      i2c.slave_rx_byte = 1'b1;
      i2c.first_byte = 1'b1;
      tick(1);
      i2c = '0;
      i2c.slave_tx_byte = 1'b1;
      i2c.master_acked = 1'b1;
      tick(1);
      i2c = '0;
      tick(1);
      chk({csr.addr_match, csr.ack, csr.continue_busy}, 3'b110);
   endtask
   task automatic t_timer;
      wr_gie(8'h02);
      service(1);
      wait_for(1, FAST + 2);
      wr_gie(8'h04);
      service(2);
   endtask
   task automatic t_prio;
      pin_en = 8'h03;
      pin_act = 8'h01;
      ep_out = 5'h07;
      ep_in = 5'h18;
      dac = 1'b1;
      tick(1);
      ep_out = 5'h00;
      ep_in = 5'h00;
      dac = 1'b0;
      epie_wd = 5'h1f;
      epie_wr = 1'b1;
      tick(1);
      epie_wr = 1'b0;
      wr_gie(8'h79);
      chk(epie_rd, 5'h1f);
      slow = 1'b1;
      for (int i = 0; i < 12; i++) begin
         if (i < 1 || i > 2) begin
            service(i);
         end
      end
   endtask
   task automatic t_pins;
      wr_gie(8'h20);
      pin_act = 8'h03;
      tick(3);
      chk(pend[10], 1'b0);
      pin_act = 8'h02;
      tick(3);
      chk(pend[10], 1'b1);
      service(10);
   endtask

   // Main sequence
   initial begin
      t_reset();
      t_busrst();
      t_hub();
      t_i2c();
      t_timer();
      t_prio();
      t_pins();
      wr_gie(8'hff);
      chk(gie_rd, 8'h7f);
      t_reset();
      conclude();
   end
endmodule
